// *** rtl/lfrdy_defs.vh ***
// register map, field positions, reset values and timing counts of the oscillator ready block
`ifndef LFRDY_DEFS_VH
`define LFRDY_DEFS_VH
`define LFRDY_ADDR_W 5
`define LFRDY_OFS_CONTROL 5'h00
`define LFRDY_OFS_STATUS 5'h04
`define LFRDY_OFS_IFLAGS 5'h08
`define LFRDY_OFS_IMASK 5'h0C
`define LFRDY_OFS_ASYNC 5'h10
`define LFRDY_OFS_PENDING 5'h14
`define LFRDY_OFS_LEVALUE 5'h18
`define LFRDY_IDX_NONE 3'h7
`define LFRDY_CTRL_RESET 32'h00000000
`define LFRDY_CTRL_MODE_LSB 0
`define LFRDY_CTRL_OSCEN_BIT 2
`define LFRDY_CTRL_TOUT_LSB 3
`define LFRDY_CTRL_LECORE_BIT 8
`define LFRDY_CTRL_LEPER_BIT 9
`define LFRDY_CTRL_PRESC_LSB 10
`define LFRDY_CTRL_MASK 32'h00000F1F
`define LFRDY_MODE_XTAL 2'h0
`define LFRDY_MODE_SINE 2'h1
`define LFRDY_MODE_DIGEXT 2'h2
`define LFRDY_IF_READY_BIT 0
`define LFRDY_IF_SYNC_BIT 1
`define LFRDY_IF_W 2
`define LFRDY_TOUT_W 15
`define LFRDY_TOUT_0 15'h0008
`define LFRDY_TOUT_1 15'h0100
`define LFRDY_TOUT_2 15'h0400
`define LFRDY_TOUT_3 15'h4000
`define LFRDY_RESP_OKAY 2'h0
`define LFRDY_RESP_SLVERR 2'h2
`endif

// *** rtl/lfrdy_ripple.v ***
// ripple prescaler that forwards the low-frequency clock to the low energy domain as an enable
`timescale 1ns/100ps
module lfrdy_ripple (
  input wire clk,
  input wire reset,
  input wire tick_in,
  input wire [1:0] prescale,
  output reg le_tick
);
  reg [2:0] count; // ripple stages, divides by 2^prescale
  wire [2:0] count_inc;
  wire [2:0] wrap_mask;
  assign count_inc = count + 3'h1;
  assign wrap_mask = (3'h1 << prescale) - 3'h1;

  // one enable pulse per 2^prescale incoming low-frequency edges
  always @(posedge clk) begin
    if (reset) begin
      count <= 3'h0;
      le_tick <= 1'b0;
    end else begin
      le_tick <= 1'b0;
      if (tick_in) begin
        if ((count & wrap_mask) == wrap_mask) begin
          count <= 3'h0;
          le_tick <= 1'b1;
        end else begin
          count <= count_inc;
        end
      end
    end
  end
endmodule // lfrdy_ripple

// *** rtl/lfrdy_top.v ***
// low-frequency oscillator ready flag, forwarding to the low energy domain, axi4-lite registers
//
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
`include "lfrdy_defs.vh"
module lfrdy_top (
  input wire clk,
  input wire reset,
  input wire lf_clk_in,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  output reg [1:0] s_axi_bresp,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  input wire [31:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output wire le_tick,
  output reg lf_osc_ready_flag,
  output wire irq
);
  // register index decode, shared by the write and read paths
  function [2:0] lfrdy_decode;
    input [31:0] addr;
    begin
      if (addr[31:`LFRDY_ADDR_W] != 27'h0 || addr[1:0] != 2'h0) begin
        lfrdy_decode = `LFRDY_IDX_NONE;
      end else begin
        case (addr[`LFRDY_ADDR_W-1:0])
          `LFRDY_OFS_CONTROL: lfrdy_decode = 3'h0;
          `LFRDY_OFS_STATUS: lfrdy_decode = 3'h1;
          `LFRDY_OFS_IFLAGS: lfrdy_decode = 3'h2;
          `LFRDY_OFS_IMASK: lfrdy_decode = 3'h3;
          `LFRDY_OFS_ASYNC: lfrdy_decode = 3'h4;
          `LFRDY_OFS_PENDING: lfrdy_decode = 3'h5;
          `LFRDY_OFS_LEVALUE: lfrdy_decode = 3'h6;
          default: lfrdy_decode = `LFRDY_IDX_NONE;
        endcase
      end
    end
  endfunction

  // software visible state
  reg [31:0] clock_unit_control; // mode, enable, timeout, le clocks, prescale
  reg [`LFRDY_IF_W-1:0] clock_unit_interrupt_flags; // sticky events
  reg [`LFRDY_IF_W-1:0] irq_mask; // same layout as the flags
  reg [31:0] async_shadow; // write side of the asynchronous register
  reg [31:0] le_value; // copy held in the low energy domain
  reg cross_domain_write_pending; // write not yet carried across

  // oscillator startup state
  reg lf_clk_q; // previous sample of the low-frequency pin
  reg [`LFRDY_TOUT_W-1:0] startup_count; // elapsed low-frequency cycles
  reg startup_done; // timeout reached, regardless of mode

  // write channel capture
  reg aw_got;
  reg w_got;
  reg [31:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;

  wire [1:0] lf_osc_source_mode = clock_unit_control[`LFRDY_CTRL_MODE_LSB+1:`LFRDY_CTRL_MODE_LSB];
  wire osc_en = clock_unit_control[`LFRDY_CTRL_OSCEN_BIT];
  wire [1:0] tout_sel = clock_unit_control[`LFRDY_CTRL_TOUT_LSB+1:`LFRDY_CTRL_TOUT_LSB];
  wire le_core_en = clock_unit_control[`LFRDY_CTRL_LECORE_BIT];
  wire le_per_en = clock_unit_control[`LFRDY_CTRL_LEPER_BIT];
  wire [1:0] le_presc = clock_unit_control[`LFRDY_CTRL_PRESC_LSB+1:`LFRDY_CTRL_PRESC_LSB];
  wire digital_external_clock_mode = (lf_osc_source_mode == `LFRDY_MODE_DIGEXT);

  // pin is synchronous to clk, so a plain edge detect gives one pulse per lf cycle
  wire lf_tick = lf_clk_in & ~lf_clk_q & osc_en;

  reg [`LFRDY_TOUT_W-1:0] tout_cycles;
  // programmed startup length in low-frequency cycles
  always @* begin
    case (tout_sel)
      2'h0: tout_cycles = `LFRDY_TOUT_0;
      2'h1: tout_cycles = `LFRDY_TOUT_1;
      2'h2: tout_cycles = `LFRDY_TOUT_2;
      default: tout_cycles = `LFRDY_TOUT_3;
    endcase
  end

  // the forwarded clock does not wait for the ready flag
  lfrdy_ripple u_ripple (
    .clk(clk),
    .reset(reset),
    .tick_in(lf_tick),
    .prescale(le_presc),
    .le_tick(le_tick)
  );

  // a transfer lands only when both low energy clock gates are open
  wire le_xfer = le_tick & le_core_en & le_per_en;

  assign s_axi_awready = ~aw_got & ~s_axi_bvalid;
  assign s_axi_wready = ~w_got & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  wire do_write = aw_got & w_got & ~s_axi_bvalid;
  wire [2:0] wr_idx = lfrdy_decode(aw_addr_q);
  wire [2:0] rd_idx = lfrdy_decode(s_axi_araddr);
  wire wr_ctrl = do_write & (wr_idx == 3'h0);
  wire wr_if = do_write & (wr_idx == 3'h2) & w_strb_q[0];
  wire wr_mask = do_write & (wr_idx == 3'h3) & w_strb_q[0];
  wire wr_async = do_write & (wr_idx == 3'h4);

  wire [31:0] strb_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}},
                           {8{w_strb_q[0]}}};

  // startup counter: counts lf cycles from enable, restarted when the oscillator enable is cleared
  always @(posedge clk) begin
    if (reset) begin
      lf_clk_q <= 1'b0;
      startup_count <= {`LFRDY_TOUT_W{1'b0}};
      startup_done <= 1'b0;
    end else begin
      lf_clk_q <= lf_clk_in;
      if (!osc_en) begin
        startup_count <= {`LFRDY_TOUT_W{1'b0}};
        startup_done <= 1'b0;
      end else if (lf_tick && !startup_done) begin
        if (startup_count == tout_cycles - 15'h0001) begin
          startup_done <= 1'b1;
        end else begin
          startup_count <= startup_count + 15'h0001;
        end
      end
    end
  end

  // the ready flag is never raised in digital external mode
  wire ready_now = startup_done & ~digital_external_clock_mode;
  wire ready_rise = ready_now & ~lf_osc_ready_flag;

  // events set sticky flags; a set in the same cycle as a write-one clear wins
  // a crossing that a fresh write restarts is not reported as carried across
  wire [`LFRDY_IF_W-1:0] if_set = {le_xfer & cross_domain_write_pending & ~wr_async,
                                   ready_rise};
  wire [`LFRDY_IF_W-1:0] if_clr = wr_if ? w_data_q[`LFRDY_IF_W-1:0] : {`LFRDY_IF_W{1'b0}};
  wire [`LFRDY_IF_W-1:0] next_if = (clock_unit_interrupt_flags & ~if_clr) | if_set;

  // control, status, flags and the crossing of the asynchronous register
  always @(posedge clk) begin
    if (reset) begin
      clock_unit_control <= `LFRDY_CTRL_RESET;
      clock_unit_interrupt_flags <= {`LFRDY_IF_W{1'b0}};
      irq_mask <= {`LFRDY_IF_W{1'b0}};
      lf_osc_ready_flag <= 1'b0;
      async_shadow <= 32'h00000000;
      le_value <= 32'h00000000;
      cross_domain_write_pending <= 1'b0;
    end else begin
      lf_osc_ready_flag <= ready_now;
      clock_unit_interrupt_flags <= next_if;
      if (wr_ctrl) begin
        clock_unit_control <= ((clock_unit_control & ~strb_mask) | (w_data_q & strb_mask))
                              & `LFRDY_CTRL_MASK;
      end
      if (wr_mask) begin
        irq_mask <= w_data_q[`LFRDY_IF_W-1:0];
      end
      if (wr_async) begin
        // a fresh write restarts the crossing even if a tick lands now
        async_shadow <= (async_shadow & ~strb_mask) | (w_data_q & strb_mask);
        cross_domain_write_pending <= 1'b1;
      end else if (le_xfer && cross_domain_write_pending) begin
        le_value <= async_shadow;
        cross_domain_write_pending <= 1'b0;
      end
    end
  end

  assign irq = |(clock_unit_interrupt_flags & irq_mask);

  // write channel: address and data taken in either order, response after both
  always @(posedge clk) begin
    if (reset) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr_q <= 32'h00000000;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LFRDY_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // status, pending and copied value are read only; writes there are refused
        if (wr_idx == 3'h0 || wr_idx == 3'h2 || wr_idx == 3'h3 || wr_idx == 3'h4) begin
          s_axi_bresp <= `LFRDY_RESP_OKAY;
        end else begin
          s_axi_bresp <= `LFRDY_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel: data registered, answered the edge after the address is taken
  always @(posedge clk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `LFRDY_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `LFRDY_RESP_OKAY;
      case (rd_idx)
        3'h0: s_axi_rdata <= clock_unit_control;
        3'h1: s_axi_rdata <= {29'h0, startup_done, osc_en, lf_osc_ready_flag};
        3'h2: s_axi_rdata <= {30'h0, clock_unit_interrupt_flags};
        3'h3: s_axi_rdata <= {30'h0, irq_mask};
        3'h4: s_axi_rdata <= async_shadow;
        3'h5: s_axi_rdata <= {31'h0, cross_domain_write_pending};
        3'h6: s_axi_rdata <= le_value;
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `LFRDY_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // lfrdy_top

// *** sim/lfrdy_assertions.sv ***
// concurrent checks on the ports of the oscillator ready block
`timescale 1ns/100ps
module lfrdy_checker (
  input wire clk,
  input wire reset,
  input wire lf_clk_in,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire le_tick,
  input wire lf_osc_ready_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  reg lf_q; // last sampled level of the low clock pin
  reg [7:0] lf_edges; // rising edges since reset, saturating
  // an upper bound on the design's own count, since any synchroniser only delays it
  always @(posedge clk) begin
    lf_q <= lf_clk_in;
    if (reset) begin
      lf_edges <= 8'h00;
    end else if (lf_clk_in && !lf_q && lf_edges != 8'hFF) begin
      lf_edges <= lf_edges + 8'h01;
    end
  end
  a_ready_after_count: assert property ($rose(lf_osc_ready_flag) |-> lf_edges >= 8'h08)
    else $error("ready flag rose before the shortest startup count");
  a_tick_single_pulse: assert property (le_tick |=> !le_tick)
    else $error("forwarded tick lasted more than one cycle");
  a_tick_needs_edge: assert property (le_tick |-> lf_edges != 8'h00)
    else $error("forwarded tick without any low clock edge");
  a_write_resp_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released after acceptance");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data did not follow the address");
endmodule // lfrdy_checker
bind lfrdy_top lfrdy_checker i_chk (.clk(clk), .reset(reset), .lf_clk_in(lf_clk_in),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .le_tick(le_tick), .lf_osc_ready_flag(lf_osc_ready_flag));

// *** sim/lfrdy_bench.sv ***
// self-checking bench for the oscillator ready block
`timescale 1ns/100ps
`include "lfrdy_defs.vh"
module lfrdy_bench;
  reg clk = 1'h0, reset = 1'h1, lf_clk_in = 1'h0, lf_run = 1'h1; // lf_run gates the low clock
  reg awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  reg [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rd = 32'h0;
  reg [2:0] lf_div = 3'h0; // divides clk by 8 to make the low clock
  reg [1:0] resp = 2'h0; // last bus response code
  wire awready, wready, bvalid, arready, rvalid, le_tick, rdy, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  integer num_errors = 0, check_count = 0, cyc = 0, ticks = 0;
  integer ticks0 = 0; // tick count at the start of a window, ticks has one driver only
  lfrdy_top i_dut (.clk(clk), .reset(reset), .lf_clk_in(lf_clk_in), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .le_tick(le_tick), .lf_osc_ready_flag(rdy),
    .irq(irq));
  initial begin
    forever #12.5 clk = ~clk;
  end
  // low clock, frozen at its level while lf_run is low; tick counter; hang guard
  always @(posedge clk) begin
    lf_div <= lf_div + 3'h1;
    if (lf_run) lf_clk_in <= lf_div[2];
    if (le_tick === 1'h1) ticks <= ticks + 1;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors = num_errors + 1;
      summarize;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // write: address and data offered together, each dropped once taken
  task wr(input [4:0] a, input [31:0] d);
    begin
      awaddr <= {27'h0, a};
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (bvalid !== 1'h1) begin
        @(posedge clk);
        if (awready === 1'h1) awvalid <= 1'h0;
        if (wready === 1'h1) wvalid <= 1'h0;
      end
      resp = bresp;
      bready <= 1'h0;
      @(posedge clk);
    end
  endtask
  // read and compare the returned word
  task rdchk(input [4:0] a, input [31:0] exp);
    begin
      araddr <= {27'h0, a};
      arvalid <= 1'h1;
      rready <= 1'h1;
      while (rvalid !== 1'h1) begin
        @(posedge clk);
        if (arready === 1'h1) arvalid <= 1'h0;
      end
      rd = rdata;
      resp = rresp;
      rready <= 1'h0;
      @(posedge clk);
      chk(rd, exp);
    end
  endtask
  task t_regs;
    begin
      rdchk(`LFRDY_OFS_CONTROL, `LFRDY_CTRL_RESET);
      wr(`LFRDY_OFS_CONTROL, 32'hFFFFFFFF);
      rdchk(`LFRDY_OFS_CONTROL, `LFRDY_CTRL_MASK);
      wr(`LFRDY_OFS_CONTROL, 32'h0);
      wr(`LFRDY_OFS_STATUS, 32'h1); // software cannot force ready
      chk(resp, `LFRDY_RESP_SLVERR);
      rdchk(5'h1C, 32'h0);
      chk(resp, `LFRDY_RESP_SLVERR);
    end
  endtask
  // crystal mode, shortest timeout of 8 low cycles (64 clk)
  task t_ready;
    integer n;
    begin
      n = 0;
      wr(`LFRDY_OFS_CONTROL, 32'h4);
      while (rdy !== 1'h1 && n < 300) begin
        @(posedge clk);
        n = n + 1;
      end
      chk(n >= 32'h00000032, 32'h1);
      chk(n < 32'h00000050, 32'h1);
      chk(rdy, 32'h1);
      rdchk(`LFRDY_OFS_STATUS, 32'h7);
      rdchk(`LFRDY_OFS_IFLAGS, 32'h1);
      wr(`LFRDY_OFS_IMASK, 32'h1);
      chk(irq, 32'h1);
      wr(`LFRDY_OFS_IFLAGS, 32'h1);
      chk(irq, 32'h0);
      rdchk(`LFRDY_OFS_IFLAGS, 32'h0);
    end
  endtask
  // digital external mode: ready stays low although ticks flow
  task t_digext;
    begin
      wr(`LFRDY_OFS_CONTROL, 32'h0);
      wr(`LFRDY_OFS_CONTROL, 32'h6);
      ticks0 = ticks;
      repeat (200) @(posedge clk);
      chk(rdy, 32'h0);
      rdchk(`LFRDY_OFS_STATUS, 32'h6);
      rdchk(`LFRDY_OFS_IFLAGS, 32'h0);
      chk(ticks - ticks0 > 20, 32'h1);
    end
  endtask
  // pending clears only with both low energy enables and a running low clock
  task t_sync;
    begin
      wr(`LFRDY_OFS_ASYNC, 32'hA5);
      repeat (50) @(posedge clk);
      rdchk(`LFRDY_OFS_PENDING, 32'h1);
      lf_run <= 1'h0;
      wr(`LFRDY_OFS_CONTROL, 32'h306);
      repeat (50) @(posedge clk);
      rdchk(`LFRDY_OFS_PENDING, 32'h1);
      lf_run <= 1'h1;
      repeat (50) @(posedge clk);
      rdchk(`LFRDY_OFS_PENDING, 32'h0);
      rdchk(`LFRDY_OFS_LEVALUE, 32'hA5);
      rdchk(`LFRDY_OFS_IFLAGS, 32'h2);
    end
  endtask
  // sine mode with the 256-cycle timeout: ready, its flag and the interrupt return
  task t_sine;
    integer n;
    begin
      n = 0;
      wr(`LFRDY_OFS_CONTROL, 32'h0);
      wr(`LFRDY_OFS_CONTROL, 32'hD);
      while (rdy !== 1'h1 && n < 32'h00000A00) begin
        @(posedge clk);
        n = n + 1;
      end
      chk(n >= 32'h000007D0, 32'h1);
      chk(n < 32'h00000900, 32'h1);
      rdchk(`LFRDY_OFS_STATUS, 32'h7);
      rdchk(`LFRDY_OFS_IFLAGS, 32'h3);
      chk(irq, 32'h1);
    end
  endtask
  task summarize;
    begin
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    t_regs;
    t_ready;
    t_digext;
    t_sync;
    t_sine;
    summarize;
  end
endmodule // lfrdy_bench
